// *** bench/ccl_cmp_model.sv ***
`timescale 1ns/10ps
module ccl_cmp_model (
    input  wire logic               clk_sys,
    input  wire logic               power_on,
    input  wire logic               hyst_on,
    input  wire logic signed [15:0] pos_mv,
    input  wire logic signed [15:0] neg_mv,
    output logic                    cmp_raw
);
    logic signed [15:0] band;
    assign band = hyst_on ? 16'sh000A : 16'sh0000;
    initial cmp_raw = 1'b0;
    // An unpowered core gives no valid decision, so its output wanders.
    always @(posedge clk_sys) begin
        if (!power_on) begin
            cmp_raw <= !cmp_raw;
        end else if (pos_mv > neg_mv + band) begin
            cmp_raw <= 1'b1;
        end else if (pos_mv < neg_mv - band) begin
            cmp_raw <= 1'b0;
        end
    end
endmodule // ccl_cmp_model

// *** bench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    import ccl_pkg::*;
    logic               clk_sys = 1'b0;
    logic               resetn = 1'b0;
    logic [CCL_AW-1:0]  bus_addr = '0;
    logic [7:0]         bus_wdata = 8'h00;
    logic               bus_wr = 1'b0;
    logic               bus_rd = 1'b0;
    logic               low_power = 1'b0;
    logic [1:0]         func = 2'h0;
    logic [1:0]         pull = 2'h0;
    logic signed [15:0] pos_mv = 16'sh0064;
    logic signed [15:0] neg_mv = 16'sh0000;
    logic [7:0]         bus_rdata;
    logic [1:0]         pull_on;
    logic               cmp_raw, cmp_power_on, cmp_hyst_on, irq, wake_req;
    int                 miscompares = 0;
    int                 samples_checked = 0;
    int                 n;
    always #50 clk_sys = ~clk_sys;
    ccl_top u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .low_power(low_power), .cmp_raw(cmp_raw),
        .cmp_power_on(cmp_power_on), .cmp_hyst_on(cmp_hyst_on),
        .pin_func_cmp(func), .pin_pull_req(pull), .pin_pull_on(pull_on),
        .irq(irq), .wake_req(wake_req)
    );
    ccl_cmp_model u_cmp (
        .clk_sys(clk_sys), .power_on(cmp_power_on), .hyst_on(cmp_hyst_on),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_raw(cmp_raw)
    );
    task automatic chk(input string nm, input logic [7:0] g,
                       input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= v;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 chk("rdata", bus_rdata, e);
    endtask
    task automatic count_wake(input int k);
        n = 0;
        repeat (k) begin
            @(posedge clk_sys);
            #1 if (wake_req === 1'b1) n++;
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(CCL_OFS_CTRL, 8'h01);
        chk("hyst", {7'h00, cmp_hyst_on}, 8'h01);
        chk("power", {7'h00, cmp_power_on}, 8'h00);
        $display("test reset done");
        wr(CCL_OFS_CTRL, 8'hFF);
        cyc(8);
        rd(CCL_OFS_CTRL, 8'h61);
        wr(CCL_OFS_STATUS, 8'h03);
        wr(CCL_OFS_CTRL, 8'h41);
        cyc(8);
        rd(CCL_OFS_CTRL, 8'h51);
        chk("power", {7'h00, cmp_power_on}, 8'h01);
        rd(CCL_OFS_STATUS, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(CCL_OFS_MASK, 8'h01);
        cyc(1);
        chk("irq", {7'h00, irq}, 8'h01);
        wr(CCL_OFS_STATUS, 8'h01);
        cyc(1);
        chk("irq", {7'h00, irq}, 8'h00);
        @(posedge clk_sys);
        pos_mv <= 16'shFF9C;
        cyc(8);
        rd(CCL_OFS_CTRL, 8'h41);
        $display("test result and flag done");
        @(posedge clk_sys);
        pos_mv <= 16'sh0064;
        wr(CCL_OFS_CTRL, 8'h01);
        cyc(8);
        rd(CCL_OFS_CTRL, 8'h01);
        chk("power", {7'h00, cmp_power_on}, 8'h00);
        wr(CCL_OFS_CTRL, 8'h41);
        cyc(8);
        wr(CCL_OFS_STATUS, 8'h03);
        rd(CCL_OFS_STATUS, 8'h00);
        @(posedge clk_sys);
        low_power <= 1'b1;
        cyc(2);
        @(posedge clk_sys);
        pos_mv <= 16'shFF9C;
        count_wake(12);
        chk("wake", n[7:0], 8'h01);
        rd(CCL_OFS_STATUS, 8'h03);
        rd(CCL_OFS_CTRL, 8'h41);
        // The flag is left set before the next change in sleep.
        @(posedge clk_sys);
        pos_mv <= 16'sh0064;
        count_wake(12);
        chk("wake", n[7:0], 8'h00);
        rd(CCL_OFS_CTRL, 8'h51);
        @(posedge clk_sys);
        low_power <= 1'b0;
        $display("test sleep wake done");
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        rd(CCL_OFS_CTRL, 8'h51);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            {func, pull} <= i[3:0];
            cyc(1);
            chk("pull", {6'h00, pull_on}, {6'h00, pull & ~func});
        end
        wr(CCL_OFS_CTRL, 8'h01);
        cyc(2);
        chk("power", {7'h00, cmp_power_on}, 8'h00);
        $display("test pins and unmapped done");
        print_verdict();
    end
endmodule // testbench

// *** core/ccl_pin_mux.sv ***
`timescale 1ns/10ps
module ccl_pin_mux
    import ccl_pkg::*;
(
    input  wire logic [1:0] pin_func_cmp,
    input  wire logic [1:0] pin_pull_req,
    output logic      [1:0] pin_pull_on
);
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_pin
            // A pin serving as comparator input never keeps its pull-high.
            assign pin_pull_on[i] = pin_pull_req[i] & ~pin_func_cmp[i];
        end
    endgenerate
endmodule // ccl_pin_mux

// *** core/ccl_sync.sv ***
`timescale 1ns/10ps
module ccl_sync
    import ccl_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [CCL_SYNC_STAGES-1:0] stage;

    // Stage 0 feeds only stage 1.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stage <= '0;
        end else begin
            stage <= {stage[CCL_SYNC_STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage[CCL_SYNC_STAGES-1];
endmodule // ccl_sync

// *** core/ccl_top.sv ***
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module ccl_top
    import ccl_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    input  wire logic [CCL_AW-1:0] bus_addr,
    input  wire logic [7:0]    bus_wdata,
    input  wire logic          bus_wr,
    input  wire logic          bus_rd,
    output logic      [7:0]    bus_rdata,
    input  wire logic          low_power,
    input  wire logic          cmp_raw,
    output logic               cmp_power_on,
    output logic               cmp_hyst_on,
    input  wire logic [1:0]    pin_func_cmp,
    input  wire logic [1:0]    pin_pull_req,
    output logic      [1:0]    pin_pull_on,
    output logic               irq,
    output logic               wake_req
);
    logic       comparator_on;
    logic       output_invert;
    logic       hysteresis_on;
    logic       raw_sync;
    logic       compare_result;
    logic       result_prev;
    logic       result_change;
    logic [1:0] status;
    logic [1:0] mask;
    logic       flag_rise;
    logic       flag_prev;
    logic       flag_set;
    logic       wr_ctrl;
    logic       wr_status;
    logic       wr_mask;
    logic [7:0] ctrl_view;
    logic [7:0] next_rdata;
    ccl_pwr_t   pwr_state;

    ccl_sync u_sync (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .async_in (cmp_raw),
        .sync_out (raw_sync)
    );

    ccl_pin_mux u_pins (
        .pin_func_cmp (pin_func_cmp),
        .pin_pull_req (pin_pull_req),
        .pin_pull_on  (pin_pull_on)
    );

    assign wr_ctrl   = bus_wr && bus_addr == CCL_OFS_CTRL;
    assign wr_status = bus_wr && bus_addr == CCL_OFS_STATUS;
    assign wr_mask   = bus_wr && bus_addr == CCL_OFS_MASK;

    // Control fields; only bits 6, 5 and 0 are writable.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            comparator_on <= CCL_RST_ON;
            output_invert <= CCL_RST_INV;
            hysteresis_on <= CCL_RST_HYS;
        end else if (wr_ctrl) begin
            comparator_on <= bus_wdata[CCL_BIT_ON];
            output_invert <= bus_wdata[CCL_BIT_INV];
            hysteresis_on <= bus_wdata[CCL_BIT_HYS];
        end
    end

    // The analog core is powered by the enable bit alone, whatever the power mode is.
    assign cmp_power_on = comparator_on;
    assign cmp_hyst_on  = hysteresis_on;

    // Off forces low; invert applied after the synchroniser.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            compare_result <= 1'b0;
        end else begin
            compare_result <= comparator_on & (raw_sync ^ output_invert);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            result_prev <= 1'b0;
        end else begin
            result_prev <= compare_result;
        end
    end

    assign result_change = compare_result ^ result_prev;

    // Power mode tracked for wake qualification.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pwr_state <= CCL_RUN;
        end else begin
            case (pwr_state)
                CCL_RUN:    if (low_power) pwr_state <= CCL_LOWPWR;
                CCL_LOWPWR: if (!low_power) pwr_state <= CCL_RUN;
                default:    pwr_state <= CCL_RUN;
            endcase
        end
    end

    // Status bit 0 is the comparator flag; bit 1 records a wake event.
    // A hardware set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            status <= CCL_RST_STATUS;
        end else begin
            status[CCL_BIT_FLAG] <= result_change |
                (status[CCL_BIT_FLAG] &
                 ~(wr_status & bus_wdata[CCL_BIT_FLAG]));
            status[CCL_BIT_WAKE] <= wake_req |
                (status[CCL_BIT_WAKE] &
                 ~(wr_status & bus_wdata[CCL_BIT_WAKE]));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            flag_prev <= 1'b0;
        end else begin
            flag_prev <= status[CCL_BIT_FLAG];
        end
    end

    // A fresh 0 to 1 flag transition; a flag already high never wakes.
    assign flag_rise = status[CCL_BIT_FLAG] & ~flag_prev;
    assign flag_set  = flag_rise & comparator_on;
    assign wake_req  = flag_set && pwr_state == CCL_LOWPWR;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mask <= CCL_RST_MASK;
        end else if (wr_mask) begin
            mask <= bus_wdata[1:0];
        end
    end

    assign irq = |(status & mask);

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[CCL_BIT_ON]  = comparator_on;
        ctrl_view[CCL_BIT_INV] = output_invert;
        ctrl_view[CCL_BIT_RES] = compare_result;
        ctrl_view[CCL_BIT_HYS] = hysteresis_on;
    end

    always_comb begin
        next_rdata = 8'h00;
        case (bus_addr)
            CCL_OFS_CTRL:   next_rdata = ctrl_view & (CCL_CTRL_WMASK | 8'h10);
            CCL_OFS_STATUS: next_rdata = {6'h00, status};
            CCL_OFS_MASK:   next_rdata = {6'h00, mask};
            default:        next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    a_off_forces_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        !comparator_on |=> !compare_result)
        else $error("result high while comparator off");

    a_result_sense: assert property (@(posedge clk_sys) disable iff (!resetn)
        comparator_on |=> compare_result == ($past(raw_sync) ^ $past(output_invert)))
        else $error("result sense wrong");

    a_change_sets_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
        result_change |=> status[CCL_BIT_FLAG])
        else $error("change did not set flag");

    a_irq_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq == ((status[0] & mask[0]) | (status[1] & mask[1])))
        else $error("interrupt gating wrong");

    a_wake_fresh: assert property (@(posedge clk_sys) disable iff (!resetn)
        wake_req |-> $rose(status[CCL_BIT_FLAG]))
        else $error("wake without fresh flag");

    // A flag that is already high blocks the wake, so only a fresh set counts.
    a_wake_lowpwr: assert property (@(posedge clk_sys) disable iff (!resetn)
        (low_power && result_change && comparator_on && !wr_ctrl &&
         !status[CCL_BIT_FLAG]) |=> wake_req)
        else $error("no wake in low power");

    a_ctrl_zero_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && bus_addr == CCL_OFS_CTRL) |=> (bus_rdata & 8'h8E) == 8'h00)
        else $error("reserved bits nonzero");

    a_hyst_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_ctrl |=> cmp_hyst_on == $past(bus_wdata[CCL_BIT_HYS]))
        else $error("hysteresis not driven");

    a_power_kept: assert property (@(posedge clk_sys) disable iff (!resetn)
        (comparator_on && low_power && !wr_ctrl) |=> cmp_power_on)
        else $error("comparator dropped in low power");

    a_pull_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        (pin_func_cmp & pin_pull_on) == 2'h0)
        else $error("pull-high left on comparator pin");

    a_on_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_ctrl |=> comparator_on == $past(bus_wdata[CCL_BIT_ON]))
        else $error("enable bit not taken");

    a_inv_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_ctrl |=> output_invert == $past(bus_wdata[CCL_BIT_INV]))
        else $error("invert bit not taken");

    a_result_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && bus_addr == CCL_OFS_CTRL) |=>
            bus_rdata[CCL_BIT_RES] == $past(compare_result))
        else $error("result bit read wrong");

    // Reset checks run without disable so that the reset values are seen.
    a_hyst_reset: assert property (@(posedge clk_sys)
        !resetn |=> cmp_hyst_on)
        else $error("hysteresis not set by reset");

    a_reset_quiet: assert property (@(posedge clk_sys)
        !resetn |=> (!irq && !wake_req && !cmp_power_on &&
                     bus_rdata == 8'h00))
        else $error("outputs active after reset");

    a_flag_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(status[CCL_BIT_FLAG]) |-> $past(result_change))
        else $error("flag set without result change");

    a_flag_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status[CCL_BIT_FLAG] && !(wr_status && bus_wdata[CCL_BIT_FLAG]))
            |=> status[CCL_BIT_FLAG])
        else $error("flag lost without clear");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_status && bus_wdata[CCL_BIT_FLAG] && !result_change)
            |=> !status[CCL_BIT_FLAG])
        else $error("flag not cleared by write");

    a_wake_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        wake_req |-> (comparator_on && pwr_state == CCL_LOWPWR))
        else $error("wake while off or running");

    a_wake_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        wake_req |=> !wake_req)
        else $error("wake longer than one cycle");

    a_wake_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        wake_req |=> status[CCL_BIT_WAKE])
        else $error("wake not recorded");

    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data outside read cycle");

    a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && bus_addr == 2'h3) |=> bus_rdata == 8'h00)
        else $error("unmapped index read nonzero");

    c_wake_blocked: cover property (@(posedge clk_sys) disable iff (!resetn)
        status[CCL_BIT_FLAG] && result_change && pwr_state == CCL_LOWPWR);
    c_power_off: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(cmp_power_on));
    c_flag_set: cover property (@(posedge clk_sys) disable iff (!resetn)
        $rose(status[CCL_BIT_FLAG]));
    c_wake: cover property (@(posedge clk_sys) disable iff (!resetn) wake_req);
    c_irq: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(irq));
endmodule // ccl_top

// *** include/ccl_pkg.sv ***
// What this block does
// - With the enable bit clear the comparator is powered off and its result reads low.
// - The invert bit passes the raw comparator output through unchanged at zero and inverted at one.
// - The result bit reads one for plus above minus, or for plus below minus when inverted.
// - The hysteresis bit drives the comparator hysteresis control and resets to one.
// - Each change of the result sets the interrupt flag, and a request is raised only if enabled.
// - In sleep or idle with the comparator on, a result change sets the flag and requests wake-up only if the flag was clear.
// - An enabled comparator keeps working in sleep or idle and is not switched off by it.
// - Selecting a comparator input function on a pin disconnects its pull-high automatically.
// - Bit 7 and bits 3 to 1 of the control register read zero and ignore writes.
package ccl_pkg;
    localparam int         CCL_AW          = 2;
    localparam logic [1:0] CCL_OFS_CTRL    = 2'h0;
    localparam logic [1:0] CCL_OFS_STATUS  = 2'h1;
    localparam logic [1:0] CCL_OFS_MASK    = 2'h2;
    localparam int         CCL_BIT_ON      = 6;
    localparam int         CCL_BIT_INV     = 5;
    localparam int         CCL_BIT_RES     = 4;
    localparam int         CCL_BIT_HYS     = 0;
    localparam int         CCL_BIT_FLAG    = 0;
    localparam int         CCL_BIT_WAKE    = 1;
    localparam logic [7:0] CCL_CTRL_WMASK  = 8'h61;
    localparam logic       CCL_RST_ON      = 1'h0;
    localparam logic       CCL_RST_INV     = 1'h0;
    localparam logic       CCL_RST_HYS     = 1'h1;
    localparam logic [1:0] CCL_RST_STATUS  = 2'h0;
    localparam logic [1:0] CCL_RST_MASK    = 2'h0;
    localparam int         CCL_SYNC_STAGES = 2;
    typedef enum logic [1:0] {CCL_RUN, CCL_LOWPWR} ccl_pwr_t;
endpackage
